// file: hdl/kwdt_defs.vh
`ifndef KWDT_DEFS_VH
`define KWDT_DEFS_VH
// ==========================================================
// register map
`define KWDT_OFS_CONTROL   8'h00
`define KWDT_OFS_KICK      8'h04
`define KWDT_CONTROL_RESET 32'h00000000
// ==========================================================
// control fields
`define KWDT_EN_BIT        0
`define KWDT_PSEL_LSB      8
`define KWDT_PSEL_MSB      12
`define KWDT_KEY_LSB       24
`define KWDT_KEY_MSB       31
`define KWDT_KEY_FIRST     8'h55
`define KWDT_KEY_SECOND    8'haa
// ==========================================================
// prescaler and timing
`define KWDT_PRESC_W       32
`define KWDT_RST_HOLD_NS   200
`define KWDT_CLK_NS        20
`define KWDT_RST_HOLD_CYC  ((`KWDT_RST_HOLD_NS + `KWDT_CLK_NS - 1) / `KWDT_CLK_NS)
`endif

// file: hdl/kwdt_key_gate.v
`timescale 1ns/10ps
`default_nettype none
`include "kwdt_defs.vh"
// ==========================================================
// two-write key sequencer for the control register
module kwdt_key_gate (
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire        ce_in,
  input  wire        wr_in,
  input  wire [31:0] wdata_in,
  output wire        commit_out
);
  localparam ST_IDLE  = 1'b0;
  localparam ST_ARMED = 1'b1;

  reg        state;
  reg        next_state;
  reg [23:0] held;
  wire [7:0] key;

  assign key = wdata_in[`KWDT_KEY_MSB:`KWDT_KEY_LSB];
  // second write must match the first in every non-key bit
  assign commit_out = ce_in & wr_in & (state == ST_ARMED) &
                      (key == `KWDT_KEY_SECOND) & (wdata_in[23:0] == held);

  // any wrong write drops back, a 0x55 write re-arms
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (wr_in && key == `KWDT_KEY_FIRST)
          next_state = ST_ARMED;
      end
      ST_ARMED: begin
        if (wr_in)
          next_state = (key == `KWDT_KEY_FIRST) ? ST_ARMED : ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // sequencer state and captured first-write bits
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      state <= ST_IDLE;
      held  <= 24'h000000;
    end else if (ce_in) begin
      state <= next_state;
      if (wr_in && key == `KWDT_KEY_FIRST)
        held <= wdata_in[23:0];
    end
  end
endmodule // kwdt_key_gate
`default_nettype wire

// file: hdl/kwdt_prescaler.v
`timescale 1ns/10ps
`default_nettype none
`include "kwdt_defs.vh"
// ==========================================================
// 32-bit prescaler with selectable expiry tap
module kwdt_prescaler (
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire        ce_in,
  input  wire        run_in,
  input  wire        tick_in,
  input  wire        clear_in,
  input  wire [4:0]  psel_in,
  output wire        expire_out
);
  reg  [`KWDT_PRESC_W-1:0] count;
  wire [`KWDT_PRESC_W:0]   limit;
  wire [`KWDT_PRESC_W:0]   count_x;

  // period is 2^(psel+1) ticks; extra bit lets psel=31 reach 2^32
  assign limit   = {{`KWDT_PRESC_W{1'b0}}, 1'b1} << ({1'b0, psel_in} + 6'h01);
  assign count_x = {1'b0, count};
  assign expire_out = run_in & tick_in & (count_x + 33'h1 == limit);

  // count ticks; restart from zero on clear or expiry
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      count <= 32'h00000000;
    end else if (ce_in) begin
      if (clear_in || !run_in)
        count <= 32'h00000000;
      else if (tick_in)
        count <= expire_out ? 32'h00000000 : count + 32'h00000001;
    end
  end
endmodule // kwdt_prescaler
`default_nettype wire

// file: hdl/kwdt_top.v
// What this block does
// - enable bit one runs, zero stops
// - enable also turns on RC clock
// - period is two to PSEL+1 ticks
// - next period starts at expiry, while reset is still held
// - wrong key sequence leaves control unchanged
// - key field and kick read zero
// - expiry issues a soft reset
// - static sleep becomes shutdown while enabled
// - stays clocked in every sleep mode
// - count freezes in debug unless peripherals run; a tick at the last count still expires
// - prescaler is 32 bits wide
`timescale 1ns/10ps
`default_nettype none
`include "kwdt_defs.vh"
// ==========================================================
// keyed watchdog top
module kwdt_top (
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire        ce_in,
  input  wire [7:0]  addr_in,
  input  wire [31:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [31:0] rdata_out,
  input  wire        rc_tick_in,
  input  wire        debug_halt_in,
  input  wire        debug_keep_run_in,
  input  wire        static_sleep_req_in,
  output wire        rc_osc_en_out,
  output wire        sleep_static_ok_out,
  output wire        sleep_force_shutdown_out,
  output reg         soft_reset_out
);
  reg        enable;
  reg  [4:0] psel;
  reg  [3:0] hold_cnt;
  wire       ctrl_wr;
  wire       kick_wr;
  wire       commit;
  wire       run;
  wire       frozen;
  wire       expire;
  wire       reenable;
  wire [31:0] hold_load;

  // ==========================================================
  // decode
  assign ctrl_wr  = wr_in & (addr_in == `KWDT_OFS_CONTROL);
  assign kick_wr  = wr_in & (addr_in == `KWDT_OFS_KICK) & enable;
  assign reenable = commit & wdata_in[`KWDT_EN_BIT] & ~enable;

  kwdt_key_gate u_key (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .ce_in      (ce_in),
    .wr_in      (ctrl_wr),
    .wdata_in   (wdata_in),
    .commit_out (commit)
  );

  // control register only loads on a good key pair
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      enable <= 1'b0;
      psel   <= 5'h00;
    end else if (ce_in && commit) begin
      enable <= wdata_in[`KWDT_EN_BIT];
      psel   <= wdata_in[`KWDT_PSEL_MSB:`KWDT_PSEL_LSB];
    end
  end

  // ==========================================================
  // counting; debug freeze holds the count, sleep never stops it
  assign frozen = debug_halt_in & ~debug_keep_run_in;
  assign run    = enable;
  assign rc_osc_en_out = enable;

  kwdt_prescaler u_presc (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .ce_in      (ce_in & ~frozen),
    .run_in     (run),
    .tick_in    (rc_tick_in),
    .clear_in   (kick_wr | reenable),
    .psel_in    (psel),
    .expire_out (expire)
  );

  // ==========================================================
  // hold count is a 32-bit constant; only its low bits are loaded
  assign hold_load = `KWDT_RST_HOLD_CYC;

  // soft reset pulse, stretched to a minimum hold; counter keeps going
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      hold_cnt       <= 4'h0;
      soft_reset_out <= 1'b0;
    end else if (ce_in) begin
      if (expire) begin
        hold_cnt       <= hold_load[3:0];
        soft_reset_out <= 1'b1;
      end else if (hold_cnt != 4'h0) begin
        hold_cnt       <= hold_cnt - 4'h1;
        soft_reset_out <= (hold_cnt != 4'h1);
      end
    end
  end

  // ==========================================================
  // sleep controller hooks
  assign sleep_static_ok_out      = ~enable;
  assign sleep_force_shutdown_out = enable & static_sleep_req_in;

  // ==========================================================
  // read port; key bits and kick always zero, unmapped reads zero
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      rdata_out <= 32'h00000000;
    end else if (ce_in) begin
      if (rd_in && addr_in == `KWDT_OFS_CONTROL)
        rdata_out <= {8'h00, 11'h000, psel, 7'h00, enable};
      else
        rdata_out <= 32'h00000000;
    end
  end
endmodule // kwdt_top
`default_nettype wire

// file: test/kwdt_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// port checker
module kwdt_checker (
  input wire        clk_in,
  input wire        rst_b_in,
  input wire        ce_in,
  input wire [7:0]  addr_in,
  input wire [31:0] wdata_in,
  input wire        wr_in,
  input wire        rd_in,
  input wire [31:0] rdata_out,
  input wire        rc_tick_in,
  input wire        debug_halt_in,
  input wire        debug_keep_run_in,
  input wire        static_sleep_req_in,
  input wire        rc_osc_en_out,
  input wire        sleep_static_ok_out,
  input wire        sleep_force_shutdown_out,
  input wire        soft_reset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  static_block_a: assert property (sleep_static_ok_out == !rc_osc_en_out)
    else $error("static sleep open while enabled");
  shutdown_swap_a: assert property (sleep_force_shutdown_out == (rc_osc_en_out && static_sleep_req_in))
    else $error("static request not turned into shutdown");
  key_read_zero_a: assert property (rd_in && ce_in && addr_in == 8'h00 |=> rdata_out[31:24] == 8'h00)
    else $error("key field read nonzero");
  kick_read_zero_a: assert property (rd_in && ce_in && addr_in == 8'h04 |=> rdata_out == 32'h00000000)
    else $error("kick register read nonzero");
  pulse_length_a: assert property ($rose(soft_reset_out) |-> soft_reset_out[*8] ##1 soft_reset_out[*2] ##1 !soft_reset_out)
    else $error("soft reset pulse not ten cycles");
  expiry_cause_a: assert property ($rose(soft_reset_out) |-> $past(rc_osc_en_out) && $past(rc_tick_in))
    else $error("soft reset without enabled tick");
  debug_freeze_a: assert property ($rose(soft_reset_out) |-> !$past(debug_halt_in && !debug_keep_run_in))
    else $error("expiry while frozen by debug");
  key_guard_a: assert property ($changed(rc_osc_en_out) |-> $past(wr_in && ce_in && addr_in == 8'h00 && wdata_in[31:24] == 8'haa))
    else $error("enable changed without second key write");
  // main scenarios reached
  cover property ($rose(soft_reset_out));
  cover property (sleep_force_shutdown_out);
  cover property (debug_halt_in && !debug_keep_run_in && rc_tick_in && rc_osc_en_out);
endmodule // kwdt_checker
bind kwdt_top kwdt_checker u_chk (.clk_in, .rst_b_in, .ce_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .rc_tick_in, .debug_halt_in, .debug_keep_run_in, .static_sleep_req_in,
  .rc_osc_en_out, .sleep_static_ok_out, .sleep_force_shutdown_out, .soft_reset_out);
`default_nettype wire

// file: test/kwdt_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
// ==========================================================
// bench top
module kwdt_bench;
  logic        clk_in = 0, rst_b_in = 0, wr_in = 0, rd_in = 0, rc_tick_in = 0;
  logic        debug_halt_in = 0, debug_keep_run_in = 0, static_sleep_req_in = 0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic        rc_osc_en_out, sleep_static_ok_out, sleep_force_shutdown_out, soft_reset_out;
  int          mismatches = 0, n_compared = 0, n;
  // clock enable tied high: freeze path left to the debug inputs
  kwdt_top u_dut (.clk_in, .rst_b_in, .ce_in(1'b1), .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .rc_tick_in, .debug_halt_in, .debug_keep_run_in, .static_sleep_req_in,
    .rc_osc_en_out, .sleep_static_ok_out, .sleep_force_shutdown_out, .soft_reset_out);
  initial forever #10 clk_in = ~clk_in;
  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1;
    @(posedge clk_in);
    wr_in <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1;
    @(posedge clk_in);
    rd_in <= 0;
    #1 `CHK("rdata", e, rdata_out)
  endtask
  task automatic cfg(input logic [23:0] f);
    wr(8'h00, {8'h55, f});
    wr(8'h00, {8'haa, f});
  endtask
  // ticks every four cycles until expiry; pulse drained first so it is not miscounted
  task automatic ticks(input int lim);
    n = 0;
    repeat (12) @(posedge clk_in);
    while (n < lim && soft_reset_out !== 1'b1) begin
      @(posedge clk_in);
      rc_tick_in <= 1;
      @(posedge clk_in);
      rc_tick_in <= 0;
      repeat (2) @(posedge clk_in);
      #1 n++;
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h00, 32'h55000101);
    wr(8'h00, 32'haa000201);
    rd(8'h00, 32'h0);
    wr(8'h00, 32'haa000101);
    rd(8'h00, 32'h0);
    for (int p = 0; p < 3; p++) begin
      cfg({11'h000, p[4:0], 8'h01});
      wr(8'h04, 32'h12345678);
      ticks(20);
      `CHK("period", 2 << p, n)
      ticks(20);
      `CHK("next period", 2 << p, n)
    end
    `CHK("osc en", 1'b1, rc_osc_en_out)
    rd(8'h00, 32'h00000201);
    ticks(5);
    wr(8'h04, 32'h0);
    ticks(20);
    `CHK("after kick", 8, n)
    debug_halt_in <= 1;
    ticks(10);
    `CHK("frozen", 10, n)
    debug_keep_run_in <= 1;
    ticks(20);
    `CHK("debug run", 8, n)
    static_sleep_req_in <= 1;
    #1 `CHK("shutdown", 1'b1, sleep_force_shutdown_out)
    `CHK("static ok", 1'b0, sleep_static_ok_out)
    cfg(24'h000200);
    rd(8'h00, 32'h00000200);
    `CHK("static ok off", 1'b1, sleep_static_ok_out)
    ticks(10);
    `CHK("stopped", 10, n)
    conclude;
  end
  // hang guard, far beyond the expected few hundred cycles
  initial begin
    #400000;
    mismatches++;
    conclude;
  end
endmodule // kwdt_bench
`default_nettype wire
